//--- compare_unit_pkg.sv
// What this block does
// - Table match with condition off does nothing; result and flag stay.
// - Table match compares the value with sixteen words, base to base+15.
// - Table word at offset n equal to the value sets result bit n.
// - Every false comparison clears its bit; the whole result is rewritten.
// - Error flag when the sixteen-word table runs past its area end.
// - Error flag when an indirect pointer is not BCD or points outside.
// - Compare value may be immediate or area word; base, result area only.
// - Range match with condition off does nothing; result and flag stay.
// - Range match reads thirty-two words, base to base+31, as pairs.
// - Even offset of a pair is the lower limit, next is the upper.
// - Range test is true when lower <= value <= upper, both inclusive.
// - Result bit k is set when pair 2k, 2k+1 holds the value.
// - Error flag when the thirty-two-word block runs past its area end.
// - Plain form repeats the comparison on every scan with condition on.
// - Range match is decoded from a settable function code, default 68.
//
// Purpose: Constants and carriers of the table and range compare unit.
// Assumes: One flat 16-bit word address space holding all data areas.
// Notes:   Area bounds below form the word map seen by the unit.

package compare_unit_pkg;

   // Function codes.
   localparam logic [7:0] FC_TABLE     = 8'h55;
   localparam logic [7:0] FC_RANGE_DEF = 8'h44;

   // Table and block lengths in words.
   localparam logic [5:0] LEN_TABLE = 6'h10;
   localparam logic [5:0] LEN_RANGE = 6'h20;

   // Word map of the data areas, inclusive bounds; DATA_HI is one past the end.
   localparam logic [15:0] IO_LO   = 16'h0000;
   localparam logic [15:0] IO_HI   = 16'h00FF;
   localparam logic [15:0] SPEC_LO = 16'h0100;
   localparam logic [15:0] SPEC_HI = 16'h01FF;
   localparam logic [15:0] HOLD_LO = 16'h0200;
   localparam logic [15:0] HOLD_HI = 16'h02FF;
   localparam logic [15:0] TMR_LO  = 16'h0300;
   localparam logic [15:0] TMR_HI  = 16'h04FF;
   localparam logic [15:0] LINK_LO = 16'h0500;
   localparam logic [15:0] LINK_HI = 16'h053F;
   localparam logic [15:0] DATA_LO = 16'h1000;
   localparam logic [15:0] DATA_HI = 16'h2A00;
   localparam logic [15:0] DATA_N  = 16'h1A00;

   // Register word offsets.
   localparam logic [2:0] REG_CTRL   = 3'h0;
   localparam logic [2:0] REG_STATUS = 3'h1;
   localparam logic [2:0] REG_MASK   = 3'h2;
   localparam logic [2:0] REG_RESULT = 3'h3;

   // Status bit positions and reset values.
   localparam int          ST_DONE   = 0;
   localparam int          ST_ERR    = 1;
   localparam logic [1:0]  MASK_RST  = 2'h0;
   localparam logic [15:0] RES_RST   = 16'h0000;

   // One operand: immediate, indirect through a pointer word, value.
   typedef struct packed {
      logic        imm;
      logic        ind;
      logic [15:0] val;
   } operand_t;

   // One issued instruction from the sequencer.
   typedef struct packed {
      logic [7:0] fcode;
      logic       cond;
      logic       diff;
      operand_t   cmp;
      operand_t   base;
      operand_t   res;
   } issue_t;

   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_PTR  = 4'h1,
      S_PTRW = 4'h2,
      S_VAL  = 4'h3,
      S_VALW = 4'h4,
      S_CHK  = 4'h5,
      S_SCAN = 4'h6,
      S_WR   = 4'h7,
      S_END  = 4'h8
   } state_t;

endpackage : compare_unit_pkg

//--- table_and_range_compare_unit.sv
// Purpose: Executes the table match and range match compare operations.
// Assumes: Data memory answers a read one cycle after it sees the strobe.
// Notes:   Memory strobes and address come from flops.
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps

module table_and_range_compare_unit
   import compare_unit_pkg::*;
(
   input  wire logic        ref_clk,   // System clock, 100 MHz.
   input  wire logic        resetn,    // Asynchronous reset, active low.
   input  wire logic        iss_valid, // Instruction issue pulse.
   input  wire issue_t      iss,       // Issued instruction and operands.
   output logic             busy,      // Unit is executing.
   output logic             done,      // One-cycle end of execution.
   output logic [15:0]      result,    // Last result word written.
   output logic             error_flag,// Flag of the last execution.
   output logic             mem_rd,    // Data memory read strobe.
   output logic             mem_wr,    // Data memory write strobe.
   output logic [15:0]      mem_addr,  // Data memory word address.
   output logic [15:0]      mem_wdata, // Data memory write data.
   input  wire logic [15:0] mem_rdata, // Read data, one cycle later.
   input  wire logic [2:0]  reg_addr,  // Register word address.
   input  wire logic [15:0] reg_wdata, // Register write data.
   input  wire logic        reg_wr,    // Register write strobe.
   input  wire logic        reg_rd,    // Register read strobe.
   output logic [15:0]      reg_rdata, // Register read data.
   output logic             irq        // Level interrupt.
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------

   // Returns the upper bound of the area holding an address, hit on top.
   function automatic logic [16:0] area_hi(input logic [15:0] a);
      logic [16:0] r;
      r = 17'h00000;
      if (a <= IO_HI) begin
         r = {1'b1, IO_HI};
      end else if (a >= SPEC_LO && a <= SPEC_HI) begin
         r = {1'b1, SPEC_HI};
      end else if (a >= HOLD_LO && a <= HOLD_HI) begin
         r = {1'b1, HOLD_HI};
      end else if (a >= TMR_LO && a <= TMR_HI) begin
         r = {1'b1, TMR_HI};
      end else if (a >= LINK_LO && a <= LINK_HI) begin
         r = {1'b1, LINK_HI};
      end else if (a >= DATA_LO && a < DATA_HI) begin
         r = {1'b1, DATA_HI - 16'h0001};
      end
      return r;
   endfunction : area_hi

   // True when a run of words from a stays inside one area.
   function automatic logic fits(input logic [15:0] a,
                                 input logic [5:0]  n);
      logic [16:0] h;
      logic [16:0] last;
      h    = area_hi(a);
      last = {1'b0, a} + {11'h000, n} - 17'h00001;
      return h[16] && (last <= {1'b0, h[15:0]});
   endfunction : fits

   // True when every digit of a word is decimal.
   function automatic logic is_bcd(input logic [15:0] w);
      return (w[3:0] <= 4'h9) && (w[7:4] <= 4'h9) &&
             (w[11:8] <= 4'h9) && (w[15:12] <= 4'h9);
   endfunction : is_bcd

   // Binary value of a four-digit decimal word.
   function automatic logic [15:0] bcd_bin(input logic [15:0] w);
      logic [15:0] r;
      r = {12'h000, w[3:0]} + 16'(w[7:4] * 4'hA)
        + 16'(w[11:8] * 7'h64) + 16'(w[15:12] * 10'h3E8);
      return r;
   endfunction : bcd_bin

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------

   logic rst_s1_q;
   logic rst_n_q;

   // Two flops release the reset in step with the clock.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rst_s1_q <= 1'b0;
         rst_n_q  <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q  <= rst_s1_q;
      end
   end

   // ----------------------------------------------------------------
   // Execution state
   // ----------------------------------------------------------------

   // Sequence state and operands.
   state_t      st_q;
   issue_t      op_q;
   logic        rng_q;
   logic [1:0]  opi_q;
   logic [15:0] opv_q [3];

   // Scan and read state.
   logic [5:0]  cnt_q;
   logic        rd_q;
   logic [4:0]  ridx_q;
   logic        pend_q;
   logic [4:0]  pidx_q;

   // Working values.
   logic [15:0] lo_q;
   logic [15:0] acc_q;
   logic        fail_q;

   // Edge memory and registers.
   logic [1:0]  prev_q;
   logic [7:0]  fc_range_q;
   logic [1:0]  sts_q;
   logic [1:0]  mask_q;

   // Decode wires.
   logic        is_tab;
   logic        is_rng;
   logic        go;
   logic [5:0]  len;
   logic        cur_ind;
   logic [16:0] cmp_hi;
   logic [16:0] res_hi;

   // Decode of the issued code; the range code is software settable.
   assign is_tab = iss.fcode == FC_TABLE;
   assign is_rng = iss.fcode == fc_range_q;
   // Plain form runs every scan; the edge form only on a rising condition.
   assign go = iss_valid && iss.cond && (is_tab || is_rng) &&
               (!iss.diff || !(is_rng ? prev_q[1] : prev_q[0]));
   assign len = rng_q ? LEN_RANGE : LEN_TABLE;
   assign cur_ind = (opi_q == 2'h0) ? op_q.cmp.ind :
                    (opi_q == 2'h1) ? op_q.base.ind : op_q.res.ind;
   assign busy = st_q != S_IDLE;

   // Top of the value and result areas.
   assign cmp_hi = area_hi(opv_q[0]);
   assign res_hi = area_hi(opv_q[2]);

   // Last condition seen per operation, for the edge-triggered form.
   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         prev_q <= 2'h0;
      end else if (iss_valid && is_tab) begin
         prev_q[0] <= iss.cond;
      end else if (iss_valid && is_rng) begin
         prev_q[1] <= iss.cond;
      end
   end

   // Read pipeline: the memory sees the strobe, data follows a cycle later.
   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pend_q <= 1'b0;
         pidx_q <= 5'h00;
      end else begin
         pend_q <= rd_q;
         pidx_q <= ridx_q;
      end
   end

   // Main sequence: resolve pointers, fetch value, scan, write the result.
   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         st_q      <= S_IDLE;
         op_q      <= '0;
         rng_q     <= 1'b0;
         opi_q     <= 2'h0;
         opv_q     <= '{default: 16'h0000};
         cnt_q     <= 6'h00;
         rd_q      <= 1'b0;
         ridx_q    <= 5'h00;
         lo_q      <= 16'h0000;
         acc_q     <= 16'h0000;
         fail_q    <= 1'b0;
         mem_wr    <= 1'b0;
         mem_addr  <= 16'h0000;
         mem_wdata <= 16'h0000;
      end else begin
         rd_q   <= 1'b0;
         mem_wr <= 1'b0;
         case (st_q)
            S_IDLE: begin
               if (go) begin
                  op_q     <= iss;
                  rng_q    <= is_rng;
                  opv_q[0] <= iss.cmp.val;
                  opv_q[1] <= iss.base.val;
                  opv_q[2] <= iss.res.val;
                  opi_q    <= 2'h0;
                  fail_q   <= 1'b0;
                  acc_q    <= 16'h0000;
                  st_q     <= S_PTR;
               end
            end
            S_PTR: begin
               if (cur_ind && !(opi_q == 2'h0 && op_q.cmp.imm)) begin
                  rd_q     <= 1'b1;
                  mem_addr <= DATA_LO + opv_q[opi_q];
                  st_q     <= S_PTRW;
               end else if (opi_q == 2'h2) begin
                  st_q <= S_VAL;
               end else begin
                  opi_q <= opi_q + 2'h1;
               end
            end
            S_PTRW: begin
               if (pend_q) begin
                  if (!is_bcd(mem_rdata) ||
                      bcd_bin(mem_rdata) >= DATA_N) begin
                     fail_q <= 1'b1;
                     st_q   <= S_END;
                  end else begin
                     opv_q[opi_q] <= DATA_LO + bcd_bin(mem_rdata);
                     st_q         <= (opi_q == 2'h2) ? S_VAL : S_PTR;
                     opi_q        <= opi_q + 2'h1;
                  end
               end
            end
            S_VAL: begin
               // Base and result name area words; no constant is taken.
               if (op_q.base.imm || op_q.res.imm) begin
                  fail_q <= 1'b1;
                  st_q   <= S_END;
               end else if (op_q.cmp.imm) begin
                  st_q <= S_CHK;
               end else if (!cmp_hi[16]) begin
                  fail_q <= 1'b1;
                  st_q   <= S_END;
               end else begin
                  rd_q     <= 1'b1;
                  mem_addr <= opv_q[0];
                  st_q     <= S_VALW;
               end
            end
            S_VALW: begin
               if (pend_q) begin
                  opv_q[0] <= mem_rdata;
                  st_q     <= S_CHK;
               end
            end
            S_CHK: begin
               // The whole table or block must sit in one area.
               if (!fits(opv_q[1], len) ||
                   !res_hi[16]) begin
                  fail_q <= 1'b1;
                  st_q   <= S_END;
               end else begin
                  cnt_q <= 6'h00;
                  st_q  <= S_SCAN;
               end
            end
            S_SCAN: begin
               // Reads issue back to back, one word a cycle.
               if (cnt_q < len) begin
                  rd_q     <= 1'b1;
                  ridx_q   <= cnt_q[4:0];
                  mem_addr <= opv_q[1] + {10'h000, cnt_q};
                  cnt_q    <= cnt_q + 6'h01;
               end
               if (pend_q) begin
                  if (!rng_q) begin
                     acc_q[pidx_q[3:0]] <= mem_rdata == opv_q[0];
                  end else if (!pidx_q[0]) begin
                     lo_q <= mem_rdata;
                  end else begin
                     acc_q[pidx_q[4:1]] <= (lo_q <= opv_q[0]) &&
                                           (opv_q[0] <= mem_rdata);
                  end
                  if ({1'b0, pidx_q} == len - 6'h01) begin
                     st_q <= S_WR;
                  end
               end
            end
            S_WR: begin
               mem_wr    <= 1'b1;
               mem_addr  <= opv_q[2];
               mem_wdata <= acc_q;
               st_q      <= S_END;
            end
            default: begin
               st_q <= S_IDLE;
            end
         endcase
      end
   end

   assign mem_rd = rd_q;

   // Outcome: result and flag change only when an execution ends.
   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         done       <= 1'b0;
         result     <= RES_RST;
         error_flag <= 1'b0;
      end else begin
         done <= st_q == S_END;
         if (st_q == S_END) begin
            error_flag <= fail_q;
         end
         if (st_q == S_WR) begin
            result <= acc_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers and interrupt
   // ----------------------------------------------------------------

   // Function code of the range operation, settable by software.
   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         fc_range_q <= FC_RANGE_DEF;
         mask_q     <= MASK_RST;
      end else if (reg_wr && reg_addr == REG_CTRL) begin
         fc_range_q <= reg_wdata[7:0];
      end else if (reg_wr && reg_addr == REG_MASK) begin
         mask_q <= reg_wdata[1:0];
      end
   end

   // Sticky status; a new event wins over a write-one clear.
   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         sts_q <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (st_q == S_END && (i == ST_DONE || fail_q)) begin
               sts_q[i] <= 1'b1;
            end else if (reg_wr && reg_addr == REG_STATUS &&
                         reg_wdata[i]) begin
               sts_q[i] <= 1'b0;
            end
         end
      end
   end

   // Read data stand in the cycle after the strobe; others read zero.
   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         reg_rdata <= 16'h0000;
      end else if (!reg_rd) begin
         reg_rdata <= 16'h0000;
      end else if (reg_addr == REG_CTRL) begin
         reg_rdata <= {8'h00, fc_range_q};
      end else if (reg_addr == REG_STATUS) begin
         reg_rdata <= {14'h0000, sts_q};
      end else if (reg_addr == REG_MASK) begin
         reg_rdata <= {14'h0000, mask_q};
      end else if (reg_addr == REG_RESULT) begin
         reg_rdata <= result;
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   assign irq = |(sts_q & mask_q);

endmodule : table_and_range_compare_unit

//--- unit_chk.sv
// Purpose: Port checks of the table and range compare unit.
// Assumes: One clock domain, reset active low.
// Notes:   Attached to the unit by the bind at the foot.
`timescale 1ns/1ps

module unit_chk
   import compare_unit_pkg::*;
(
   input wire logic        ref_clk,    // Unit clock.
   input wire logic        resetn,     // Reset, active low.
   input wire logic        iss_valid,  // Issue pulse.
   input wire issue_t      iss,        // Issued instruction.
   input wire logic        busy,       // Unit is executing.
   input wire logic        done,       // End of execution.
   input wire logic [15:0] result,     // Result word.
   input wire logic        error_flag, // Flag of last execution.
   input wire logic        mem_rd,     // Memory read strobe.
   input wire logic        mem_wr,     // Memory write strobe.
   input wire logic [15:0] mem_wdata   // Memory write data.
);
   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   // All checks use the unit clock and stop while reset is low.
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   a_cond_off_quiet: assert property (
      iss_valid && !busy && !iss.cond |=> !busy && $stable(result))
      else $error("condition off issue started the unit");
   a_plain_starts: assert property (
      iss_valid && !busy && iss.cond && !iss.diff && iss.fcode == FC_TABLE
      |=> busy) else $error("plain table issue was not taken");
   a_done_bounded: assert property (
      $rose(busy) |-> ##[1:80] done) else $error("execution never ended");
   a_write_done: assert property (
      mem_wr |=> done && !error_flag)
      else $error("result write not followed by clean done");
   a_write_result: assert property (
      mem_wr |-> result == mem_wdata)
      else $error("result output differs from written word");
   a_err_no_write: assert property (
      done && error_flag |-> !$past(mem_wr))
      else $error("result written on a failed execution");
   a_flag_at_done: assert property (
      $changed(error_flag) |-> done)
      else $error("error flag moved outside done");
   a_result_at_write: assert property (
      $changed(result) |-> mem_wr)
      else $error("result moved without a write");
   a_quiet_idle: assert property (
      !busy && !$past(busy) |-> !mem_rd && !mem_wr)
      else $error("memory strobe while idle");
endmodule : unit_chk

bind table_and_range_compare_unit unit_chk u_chk (
   .ref_clk(ref_clk), .resetn(resetn), .iss_valid(iss_valid), .iss(iss),
   .busy(busy), .done(done), .result(result), .error_flag(error_flag),
   .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata));

//--- mem_model.sv
// Purpose: Data memory seen by the compare unit.
// Assumes: Read data stand only in the cycle after the strobe.
// Notes:   Outside that cycle the data bus toggles every cycle.
`timescale 1ns/1ps

module mem_model (
   input  wire logic        ref_clk,   // Unit clock.
   input  wire logic        mem_rd,    // Read strobe.
   input  wire logic        mem_wr,    // Write strobe.
   input  wire logic [15:0] mem_addr,  // Word address.
   input  wire logic [15:0] mem_wdata, // Write data.
   output logic      [15:0] mem_rdata  // Read data.
);
   logic [15:0] mem [0:65535];

   // All words start at zero so untouched areas read cleanly.
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 16'h0000;
      end
      mem_rdata = 16'h0000;
   end

   // Stale read data are inverted so a late sample is caught.
   always @(posedge ref_clk) begin
      if (mem_rd) begin
         mem_rdata <= mem[mem_addr];
      end else begin
         mem_rdata <= ~mem_rdata;
      end
      if (mem_wr) begin
         mem[mem_addr] <= mem_wdata;
      end
   end
endmodule : mem_model

//--- table_and_range_compare_unit_bench.sv
// Purpose: Self-checking bench of the table and range compare unit.
// Assumes: Result word kept low in data memory, limits ordered.
// Notes:   Memory contents are set straight into the model.
`timescale 1ns/1ps

module table_and_range_compare_unit_bench;
   import compare_unit_pkg::*;
   localparam logic [15:0] TB = 16'h1010;  // Table base.
   localparam logic [15:0] BB = 16'h1040;  // Block base.
   localparam logic [15:0] RES = 16'h1100;
   logic        ref_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        iss_valid = 1'b0;
   issue_t      iss = '0;
   logic        busy, done, error_flag, mem_rd, mem_wr, irq;
   logic [15:0] result, mem_addr, mem_wdata, mem_rdata, reg_rdata;
   logic [2:0]  reg_addr = 3'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   int          errors = 0;
   int          samples_checked = 0;

   table_and_range_compare_unit u_table_and_range_compare_unit (
      .ref_clk(ref_clk), .resetn(resetn), .iss_valid(iss_valid),
      .iss(iss), .busy(busy), .done(done), .result(result),
      .error_flag(error_flag), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
   mem_model u_mem_model (.ref_clk(ref_clk), .mem_rd(mem_rd),
      .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata));

   // 100 MHz clock.
   always #5 ref_clk = ~ref_clk;

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic operand_t opr(input logic i, n,
                                    input logic [15:0] v);
      opr = '{imm: i, ind: n, val: v};
   endfunction : opr

   task automatic chk(input string nm, input logic [15:0] exp, got);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic report_and_stop;
      if (errors == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop

   // Issues one instruction and waits a bounded time for done.
   task automatic run(input logic [7:0] fc, input logic c, d,
                      input operand_t a, b, input logic want);
      int n;
      @(posedge ref_clk);
      iss_valid <= 1'b1;
      iss <= '{fcode: fc, cond: c, diff: d, cmp: a, base: b,
               res: opr(1'b0, 1'b0, RES)};
      @(posedge ref_clk);
      iss_valid <= 1'b0;
      #1;
      for (n = 0; n < 100 && done !== 1'b1; n++) begin
         @(posedge ref_clk);
         #1;
      end
      chk("done", {15'h0, want}, {15'h0, done === 1'b1});
   endtask : run

   task automatic reg_write(input logic [2:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
   endtask : reg_write

   task automatic reg_check(input logic [2:0] a, input logic [15:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk("register", e, reg_rdata);
   endtask : reg_check

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   // Table match with immediate and area compare values.
   task automatic t_table;
      logic [15:0] e;
      for (int n = 0; n < 16; n++) begin
         u_mem_model.mem[TB + n] = ((16'hC445 >> n) & 16'h1) != 0 ?
                                   16'h0210 : {n[3:0], 12'h001};
      end
      for (int k = 0; k < 3; k++) begin
         u_mem_model.mem[RES] = 16'hFFFF;
         u_mem_model.mem[16'h1200] = (k == 2) ? 16'h7001 : 16'h0210;
         e = (k == 2) ? 16'h0080 : 16'hC445;
         run(FC_TABLE, 1'b1, 1'b0, opr(k == 0, 1'b0, (k == 0) ? 16'h0210 :
             16'h1200), opr(1'b0, 1'b0, TB), 1'b1);
         chk("table result", e, result);
         chk("table word", e, u_mem_model.mem[RES]);
      end
   endtask : t_table

   // Range match with edge values on both limits.
   task automatic t_range;
      int          kk [7] = '{0, 1, 2, 3, 4, 5, 15};
      logic [31:0] pr [7] = '{32'h02100210, 32'h0211FFFF, 32'h0000020F,
         32'h02000210, 32'h01000300, 32'h0000FFFF, 32'h0210FFFF};
      for (int k = 0; k < 16; k++) begin
         u_mem_model.mem[BB + 2 * k] = 16'h8000;
         u_mem_model.mem[BB + 2 * k + 1] = 16'h9000;
      end
      for (int i = 0; i < 7; i++) begin
         u_mem_model.mem[BB + 2 * kk[i]] = pr[i][31:16];
         u_mem_model.mem[BB + 2 * kk[i] + 1] = pr[i][15:0];
      end
      u_mem_model.mem[RES] = 16'hFFFF;
      run(FC_RANGE_DEF, 1'b1, 1'b0, opr(1'b1, 1'b0, 16'h0210),
          opr(1'b0, 1'b0, BB), 1'b1);
      chk("range word", 16'h8039, u_mem_model.mem[RES]);
      chk("range flag", 16'h0000, {15'h0, error_flag});
   endtask : t_range

   // Table and block just inside and just past an area end.
   task automatic t_bounds;
      logic [15:0] bs [6] = '{16'h29F0, 16'h29F1, 16'h00F0, 16'h00F1,
                              16'h29E0, 16'h29E1};
      for (int i = 0; i < 6; i++) begin
         u_mem_model.mem[RES] = 16'hFFFF;
         run((i < 4) ? FC_TABLE : FC_RANGE_DEF, 1'b1, 1'b0,
             opr(1'b1, 1'b0, 16'h7777), opr(1'b0, 1'b0, bs[i]), 1'b1);
         chk("bound flag", {15'h0, i[0]}, {15'h0, error_flag});
         chk("bound word", i[0] ? 16'hFFFF : 16'h0000,
             u_mem_model.mem[RES]);
      end
   endtask : t_bounds

   // Indirect compare value: good, boundary, not BCD, out of area.
   task automatic t_indirect;
      logic [15:0] pt [4] = '{16'h0123, 16'h6655, 16'h012A, 16'h6656};
      u_mem_model.mem[16'h107B] = 16'h4242;
      u_mem_model.mem[16'h29FF] = 16'h4242;
      u_mem_model.mem[TB + 3] = 16'h4242;
      for (int i = 0; i < 4; i++) begin
         u_mem_model.mem[RES] = 16'hFFFF;
         u_mem_model.mem[16'h1005] = pt[i];
         run(FC_TABLE, 1'b1, 1'b0, opr(1'b0, 1'b1, 16'h0005),
             opr(1'b0, 1'b0, TB), 1'b1);
         chk("indirect flag", {15'h0, i[1]}, {15'h0, error_flag});
         chk("indirect word", i[1] ? 16'hFFFF : 16'h0008,
             u_mem_model.mem[RES]);
      end
      run(FC_TABLE, 1'b1, 1'b0, opr(1'b1, 1'b0, 16'h4242),
          opr(1'b1, 1'b0, TB), 1'b1);
      chk("imm base flag", 16'h0001, {15'h0, error_flag});
   endtask : t_indirect

   // Plain form repeats; edge form needs the condition to drop first.
   task automatic t_repeat;
      logic [2:0] sq [5] = '{3'b101, 3'b101, 3'b110, 3'b010, 3'b111};
      for (int i = 0; i < 5; i++) begin
         run(FC_TABLE, sq[i][2], sq[i][1], opr(1'b1, 1'b0, 16'h0210),
             opr(1'b0, 1'b0, TB), sq[i][0]);
      end
   endtask : t_repeat

   // Registers, interrupt and a moved range function code.
   task automatic t_regs;
      reg_check(REG_CTRL, 16'h0044);
      reg_check(3'h7, 16'h0000);
      reg_write(REG_MASK, 16'h0000);
      chk("irq masked", 16'h0000, {15'h0, irq});
      reg_write(REG_MASK, 16'h0001);
      chk("irq raised", 16'h0001, {15'h0, irq});
      reg_write(REG_STATUS, 16'h0003);
      chk("irq cleared", 16'h0000, {15'h0, irq});
      reg_check(REG_STATUS, 16'h0000);
      reg_write(REG_CTRL, 16'h0033);
      run(FC_RANGE_DEF, 1'b1, 1'b0, opr(1'b1, 1'b0, 16'h0210),
          opr(1'b0, 1'b0, BB), 1'b0);
      run(8'h33, 1'b0, 1'b0, opr(1'b1, 1'b0, 16'h0210),
          opr(1'b0, 1'b0, BB), 1'b0);
      run(8'h33, 1'b1, 1'b0, opr(1'b1, 1'b0, 16'h0210),
          opr(1'b0, 1'b0, BB), 1'b1);
      chk("irq done", 16'h0001, {15'h0, irq});
      reg_check(REG_RESULT, 16'h8039);
   endtask : t_regs

   // Main sequence after a 16-cycle reset.
   initial begin
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge ref_clk);
      t_table;
      t_range;
      t_bounds;
      t_indirect;
      t_repeat;
      t_regs;
      report_and_stop;
   end

   // Watchdog against a hung handshake.
   initial begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      report_and_stop;
   end
endmodule : table_and_range_compare_unit_bench
